// ==== shared/dfl_pkg.sv ====
// Purpose: Shared constants and types for the drive data and fault logger.
// Assumes: One 20 MHz clock; registers reached over AHB-Lite.
// Notes:   Every offset, width and count used by more than one file lives here.
package dfl_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ     = 20_000_000;
  localparam int unsigned SAMPLE_MS  = 160;
  localparam int unsigned SAMPLE_CYC = CLK_HZ / 1000 * SAMPLE_MS;
  localparam int unsigned SEC_CYC    = CLK_HZ;
  localparam int unsigned HOUR_SEC   = 3600;
  localparam int unsigned WS_PER_KWH = 3_600_000;
  // ----------------------------------------------------------------
  // Log shapes and limits
  // ----------------------------------------------------------------
  localparam int unsigned DLOG_DEPTH = 20;
  localparam int unsigned TLOG_DEPTH = 10;
  localparam int unsigned QTY_W      = 16;
  localparam int unsigned DIN_W      = 8;
  localparam int unsigned DLOG_W     = DIN_W + 8 * QTY_W;
  localparam int unsigned CODE_W     = 7;
  localparam int unsigned VAL_W      = 14;
  localparam int unsigned HRS_W      = 21;
  localparam int unsigned TLOG_W     = CODE_W + VAL_W + HRS_W;
  localparam logic [6:0]  CODE_MAX   = 7'h63;
  localparam logic [13:0] VALUE_MAX  = 14'h270F;
  localparam logic [20:0] HOURS_MAX  = 21'h13D620;
  localparam logic [15:0] CNT_MAX    = 16'h270F;
  localparam logic [6:0]  OV_ALARM   = 7'h07;
  localparam logic [3:0]  FIELD_LAST = 4'h8;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_CWORD    = 8'h08;
  localparam logic [7:0] OFS_DSEL     = 8'h10;
  localparam logic [7:0] OFS_DDATA    = 8'h14;
  localparam logic [7:0] OFS_TSEL     = 8'h18;
  localparam logic [7:0] OFS_TCODE    = 8'h1C;
  localparam logic [7:0] OFS_THOURS   = 8'h20;
  localparam logic [7:0] OFS_ENERGY   = 8'h24;
  localparam logic [7:0] OFS_CONN     = 8'h28;
  localparam logic [7:0] OFS_OTEMP    = 8'h2C;
  localparam logic [7:0] OFS_OVOLT    = 8'h30;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h34;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h38;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h3C;
  // Control bits, interrupt bits.
  localparam int unsigned CTRL_INIT = 0;
  localparam int unsigned CTRL_ESEL = 1;
  localparam int unsigned IRQ_N     = 4;
  localparam int unsigned IRQ_TRIP  = 0;
  localparam int unsigned IRQ_SNAP  = 1;
  localparam int unsigned IRQ_FROZE = 2;
  localparam int unsigned IRQ_REJ   = 3;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  // Sampling states, Gray along idle, run, frozen.
  typedef enum logic [1:0] {
    DFL_IDLE   = 2'h0,
    DFL_RUN    = 2'h1,
    DFL_FROZEN = 2'h3
  } dfl_run_e;
endpackage

// ==== shared/dfl_log_if.sv ====
// Purpose: Push and read signals between the logger core and one shift log.
// Assumes: Same clock on both sides.
// Notes:   Two read ports so bus and panel never contend.
`timescale 1ns/100ps
interface dfl_log_if #(parameter int W = 8, parameter int D = 20);
  logic                 push;
  logic                 clr;
  logic [W-1:0]         wdata;
  logic [$clog2(D)-1:0] idx_a;
  logic [$clog2(D)-1:0] idx_b;
  logic [W-1:0]         dat_a;
  logic [W-1:0]         dat_b;
  modport owner (output push, clr, wdata, idx_a, idx_b, input dat_a, dat_b);
  modport store (input push, clr, wdata, idx_a, idx_b, output dat_a, dat_b);
endinterface

// ==== core/dfl_shift_log.sv ====
// Purpose: Shift-register log, entry 0 newest, entry D-1 oldest.
// Assumes: Push and clear come from the same clock domain.
// Notes:   Contents have no reset; only clr empties them.
`timescale 1ns/100ps
module dfl_shift_log #(
  parameter int W = 8,
  parameter int D = 20
) (
  input wire logic clock_i,
  dfl_log_if.store lg
);
  logic [W-1:0] mem [D];

  initial begin
    if (D < 2) $error("dfl_shift_log needs a depth of at least two");
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // shift on push
  // Entry 0 takes the pushed word, every other entry its younger neighbour; the oldest falls off the end.
  for (genvar g = 0; g < D; g++) begin : g_ent
    always_ff @(posedge clock_i) begin
      if (lg.clr) begin
        mem[g] <= '0;
      end else if (lg.push) begin
        if (g == 0) mem[g] <= lg.wdata;
        else        mem[g] <= mem[(g > 0) ? g - 1 : 0];
      end
    end
  end

  // Reads out of range return zero.
  assign lg.dat_a = (int'(lg.idx_a) < D) ? mem[lg.idx_a] : '0;
  assign lg.dat_b = (int'(lg.idx_b) < D) ? mem[lg.idx_b] : '0;

  AST_SHIFT_NEWEST: assert property (@(posedge clock_i)
    lg.push && !lg.clr |=> mem[0] == $past(lg.wdata))
    else $error("newest entry is not the pushed word");
  AST_SHIFT_OLDER: assert property (@(posedge clock_i)
    lg.push && !lg.clr |=> mem[D-1] == $past(mem[D-2]))
    else $error("oldest entry did not move one deeper");
endmodule

// ==== core/dfl_logger.sv ====
// Purpose: Service records of a motor converter: counters, data log, trip log.
// Assumes: AHB-Lite slave, single word transfers; drive values on clock_i.
// Notes:   Trip log ignores rst_i; only a manual initialisation clears it.
// Functional notes
// - Data log holds twenty snapshots, index one newest, twenty oldest.
// - After start is accepted, take a snapshot every 160 ms.
// - Trip or stop freezes sampling; the twenty snapshots stay readable.
// - Digital inputs logged as eight bits, first terminal is the MSB.
// - Logged control word changes only through serial link writes.
// - Snapshot also holds status, reference, feedback, frequency, volts, amps, DC.
// - Data log readable over the bus and from the local display.
// - Each trip pushes its error code 0..99 into a ten-entry log.
// - Each trip logs running hours, up to 130000.0, same ordering.
// - Each trip logs its measured value, limited to 0..9999.
// - Trip logs clear only on manual initialisation.
// - Energy counter adds kWh from mean power over each hour.
// - Count every application of supply voltage.
// - Count every heat-sink overtemperature event.
// - Count DC overvoltage events only while alarm 7 is active.
// - Energy reset select: 0 none, 1 reset on operator confirmation.
// - Energy reset selection through the serial port is refused.
`timescale 1ns/100ps
module dfl_logger #(
  parameter int unsigned SAMPLE_CYCLES = dfl_pkg::SAMPLE_CYC,
  parameter int unsigned SEC_CYCLES    = dfl_pkg::SEC_CYC
) (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        serial_access_i,
  input  wire logic        ok_key_i,
  input  wire logic        start_i,
  input  wire logic        stop_i,
  input  wire logic        trip_i,
  input  wire logic [6:0]  trip_code_i,
  input  wire logic [13:0] trip_value_i,
  input  wire logic [20:0] run_hours_i,
  input  wire logic [7:0]  din_pin_i,
  input  wire logic        supply_pin_i,
  input  wire logic [15:0] status_word_i,
  input  wire logic [15:0] ref_i,
  input  wire logic [15:0] fb_i,
  input  wire logic [15:0] freq_i,
  input  wire logic [15:0] volt_i,
  input  wire logic [15:0] curr_i,
  input  wire logic [15:0] dc_i,
  input  wire logic [15:0] power_w_i,
  input  wire logic        heat_ot_i,
  input  wire logic        ov_event_i,
  input  wire logic [6:0]  active_alarm_i,
  input  wire logic [4:0]  panel_idx_i,
  input  wire logic [3:0]  panel_field_i,
  output logic      [15:0] panel_data_o,
  output logic             irq_o
);
  localparam int DD = dfl_pkg::DLOG_DEPTH;
  localparam int TD = dfl_pkg::TLOG_DEPTH;

  initial begin
    if (SAMPLE_CYCLES < 2 || SEC_CYCLES < 2) $error("timing counts too small");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Three stages per pin; a change is taken once stages two and three agree.
  logic [8:0] s1;
  logic [8:0] s2;
  logic [8:0] s3;
  logic [8:0] pin_q;
  logic       supply_q_d;
  for (genvar b = 0; b < 9; b++) begin : g_sync
    always_ff @(posedge clock_i) begin
      s1[b] <= (b < 8) ? din_pin_i[(b < 8) ? b : 0] : supply_pin_i;
      s2[b] <= s1[b];
      s3[b] <= s2[b];
      if (rst_i)              pin_q[b] <= 1'b0;
      else if (s2[b] == s3[b]) pin_q[b] <= s3[b];
    end
  end

  // ----------------------------------------------------------------
  // Sampling state and period timer
  // ----------------------------------------------------------------
  dfl_pkg::dfl_run_e state;
  dfl_pkg::dfl_run_e next_state;
  logic [31:0]       samp_cnt;
  logic              snap;

  // Trip and stop outrank a start arriving in the same cycle.
  always_comb begin
    next_state = state;
    case (state)
      dfl_pkg::DFL_RUN: begin
        if (trip_i || stop_i) next_state = dfl_pkg::DFL_FROZEN;
      end
      default: begin
        if (start_i && !trip_i && !stop_i) next_state = dfl_pkg::DFL_RUN;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) state <= dfl_pkg::DFL_IDLE;
    else       state <= next_state;
  end

  // 160 ms period
  // The timer restarts on every accepted start so the first entry is one period later.
  always_ff @(posedge clock_i) begin
    if (rst_i || state != dfl_pkg::DFL_RUN || snap) samp_cnt <= '0;
    else                                            samp_cnt <= samp_cnt + 32'h1;
  end
  assign snap = (state == dfl_pkg::DFL_RUN) && !trip_i && !stop_i &&
                (samp_cnt == SAMPLE_CYCLES - 1);

  // ----------------------------------------------------------------
  // Logs
  // ----------------------------------------------------------------
  dfl_log_if #(.W(dfl_pkg::DLOG_W), .D(DD)) dlog ();
  dfl_log_if #(.W(dfl_pkg::TLOG_W), .D(TD)) tlog ();

  dfl_shift_log #(.W(dfl_pkg::DLOG_W), .D(DD)) u_dlog (
    .clock_i (clock_i),
    .lg      (dlog)
  );
  dfl_shift_log #(.W(dfl_pkg::TLOG_W), .D(TD)) u_tlog (
    .clock_i (clock_i),
    .lg      (tlog)
  );

  logic [15:0] cword;
  logic        init_req;
  // snapshot layout
  // Input bit 7 is the first terminal; quantities follow in fixed field order.
  assign dlog.push  = snap;
  assign dlog.clr   = 1'b0;
  assign dlog.wdata = {dc_i, curr_i, volt_i, freq_i, fb_i, ref_i, status_word_i,
                       cword, pin_q[7:0]};

  assign tlog.push  = trip_i && !init_req;
  assign tlog.wdata = {(run_hours_i  > dfl_pkg::HOURS_MAX) ? dfl_pkg::HOURS_MAX : run_hours_i,
                       (trip_value_i > dfl_pkg::VALUE_MAX) ? dfl_pkg::VALUE_MAX : trip_value_i,
                       (trip_code_i  > dfl_pkg::CODE_MAX)  ? dfl_pkg::CODE_MAX  : trip_code_i};
  assign tlog.clr   = init_req;
  assign tlog.idx_b = '0;

  // Field picker shared by bus and panel paths.
  function automatic logic [15:0] pick(input logic [dfl_pkg::DLOG_W-1:0] e,
                                       input logic [3:0] f);
    logic [15:0] r;
    r = '0;
    if (f == 4'h0) r = {8'h00, e[7:0]};
    else if (f <= dfl_pkg::FIELD_LAST) r = e[8 + 16 * (f - 4'h1) +: 16];
    return r;
  endfunction

  // panel read path
  // Index one on the display is entry zero in storage.
  assign dlog.idx_b = (panel_idx_i == 5'h0) ? 5'h0 : panel_idx_i - 5'h1;
  always_ff @(posedge clock_i) begin
    if (rst_i) panel_data_o <= '0;
    else       panel_data_o <= pick(dlog.dat_b, panel_field_i);
  end

  // ----------------------------------------------------------------
  // Event counters
  // ----------------------------------------------------------------
  logic [15:0] conn_cnt;
  logic [15:0] otemp_cnt;
  logic [15:0] ovolt_cnt;
  always_ff @(posedge clock_i) begin
    if (rst_i) supply_q_d <= 1'b0;
    else       supply_q_d <= pin_q[8];
  end

  // Counters saturate at 9999 rather than wrap, so a full count stays visible.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      conn_cnt  <= '0;
      otemp_cnt <= '0;
      ovolt_cnt <= '0;
    end else begin
      if (pin_q[8] && !supply_q_d && conn_cnt != dfl_pkg::CNT_MAX)
        conn_cnt <= conn_cnt + 16'h1;
      if (heat_ot_i && otemp_cnt != dfl_pkg::CNT_MAX)
        otemp_cnt <= otemp_cnt + 16'h1;
      if (ov_event_i && active_alarm_i == dfl_pkg::OV_ALARM &&
          ovolt_cnt != dfl_pkg::CNT_MAX)
        ovolt_cnt <= ovolt_cnt + 16'h1;
    end
  end

  // ----------------------------------------------------------------
  // Energy counter
  // ----------------------------------------------------------------
  logic [31:0] sec_cnt;
  logic [11:0] hour_sec;
  logic [35:0] ws_acc;
  logic [35:0] ws_hour;
  logic [31:0] kwh;
  logic        esel;
  logic        e_clear;
  logic        sec_tick;
  assign sec_tick = (sec_cnt == SEC_CYCLES - 1);
  assign e_clear  = esel && ok_key_i;

  // hourly mean power
  // Power is summed once a second; at each hour end the sum is moved to a
  // pending pool that is drained one kWh per cycle, which avoids a divider.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sec_cnt  <= '0;
      hour_sec <= '0;
      ws_acc   <= '0;
      ws_hour  <= '0;
      kwh      <= '0;
    end else begin
      sec_cnt <= sec_tick ? 32'h0 : sec_cnt + 32'h1;
      if (sec_tick) begin
        if (hour_sec == 12'(dfl_pkg::HOUR_SEC - 1)) begin
          hour_sec <= '0;
          ws_acc   <= '0;
          ws_hour  <= ws_hour + ws_acc + 36'(power_w_i);
        end else begin
          hour_sec <= hour_sec + 12'h1;
          ws_acc   <= ws_acc + 36'(power_w_i);
        end
      end else if (ws_hour >= 36'(dfl_pkg::WS_PER_KWH)) begin
        ws_hour <= ws_hour - 36'(dfl_pkg::WS_PER_KWH);
        kwh     <= kwh + 32'h1;
      end
      if (e_clear) begin
        kwh     <= '0;
        ws_hour <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  // Reads take one wait state so a read always sees a write just before it.
  logic        wr_pend;
  logic        rd_pend;
  logic [7:0]  a_ofs;
  localparam int IRQ_W = dfl_pkg::IRQ_N;
  logic        req;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_en;
  logic [IRQ_W-1:0] irq_evt;
  logic [IRQ_W-1:0] irq_clr;
  logic [4:0]  dsel_idx;
  logic [3:0]  dsel_fld;
  logic [3:0]  tsel_idx;
  logic        rej;
  logic [31:0] rdata;
  logic        wr_ok;

  assign req   = hsel_i && hready_i && htrans_i == dfl_pkg::HTRANS_NONSEQ;
  assign wr_ok = wr_pend;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wr_pend     <= 1'b0;
      rd_pend     <= 1'b0;
      a_ofs       <= '0;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      wr_pend     <= req && hwrite_i;
      rd_pend     <= req && !hwrite_i;
      hreadyout_o <= !(req && !hwrite_i);
      if (req) a_ofs <= haddr_i[7:0];
    end
  end

  // Register writes; unmapped offsets are ignored.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cword    <= '0;
      esel     <= 1'b0;
      init_req <= 1'b0;
      irq_en   <= '0;
      dsel_idx <= 5'h1;
      dsel_fld <= '0;
      tsel_idx <= 4'h1;
    end else begin
      init_req <= wr_ok && a_ofs == dfl_pkg::OFS_CTRL && hwdata_i[dfl_pkg::CTRL_INIT];
      if (e_clear) esel <= 1'b0;
      if (wr_ok) begin
        if (a_ofs == dfl_pkg::OFS_CTRL) begin
          if (!serial_access_i) esel <= hwdata_i[dfl_pkg::CTRL_ESEL] && !e_clear;
        end else if (a_ofs == dfl_pkg::OFS_CWORD) begin
          if (serial_access_i) cword <= hwdata_i[15:0];
        end else if (a_ofs == dfl_pkg::OFS_DSEL) begin
          dsel_idx <= hwdata_i[4:0];
          dsel_fld <= hwdata_i[11:8];
        end else if (a_ofs == dfl_pkg::OFS_TSEL) begin
          tsel_idx <= hwdata_i[3:0];
        end else if (a_ofs == dfl_pkg::OFS_IRQ_EN) begin
          irq_en <= hwdata_i[IRQ_W-1:0];
        end
      end
    end
  end

  assign dlog.idx_a = (dsel_idx == 5'h0) ? 5'h0 : dsel_idx - 5'h1;
  assign tlog.idx_a = (tsel_idx == 4'h0) ? 4'h0 : tsel_idx - 4'h1;

  always_comb begin
    rdata = '0;
    if (a_ofs == dfl_pkg::OFS_CTRL)        rdata = {30'h0, esel, 1'b0};
    else if (a_ofs == dfl_pkg::OFS_STATUS) rdata = {29'h0, esel, state};
    else if (a_ofs == dfl_pkg::OFS_CWORD)  rdata = {16'h0, cword};
    else if (a_ofs == dfl_pkg::OFS_DSEL)   rdata = {20'h0, dsel_fld, 3'h0, dsel_idx};
    else if (a_ofs == dfl_pkg::OFS_DDATA)  rdata = {16'h0, pick(dlog.dat_a, dsel_fld)};
    else if (a_ofs == dfl_pkg::OFS_TSEL)   rdata = {28'h0, tsel_idx};
    else if (a_ofs == dfl_pkg::OFS_TCODE)  rdata = {2'h0, tlog.dat_a[20:7], 9'h0,
                                                    tlog.dat_a[6:0]};
    else if (a_ofs == dfl_pkg::OFS_THOURS) rdata = {11'h0, tlog.dat_a[41:21]};
    else if (a_ofs == dfl_pkg::OFS_ENERGY) rdata = kwh;
    else if (a_ofs == dfl_pkg::OFS_CONN)   rdata = {16'h0, conn_cnt};
    else if (a_ofs == dfl_pkg::OFS_OTEMP)  rdata = {16'h0, otemp_cnt};
    else if (a_ofs == dfl_pkg::OFS_OVOLT)  rdata = {16'h0, ovolt_cnt};
    else if (a_ofs == dfl_pkg::OFS_IRQ_STAT) rdata = {28'h0, irq_stat};
    else if (a_ofs == dfl_pkg::OFS_IRQ_EN) rdata = {28'h0, irq_en};
  end

  always_ff @(posedge clock_i) begin
    if (rst_i)        hrdata_o <= '0;
    else if (rd_pend) hrdata_o <= rdata;
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign rej = wr_ok && a_ofs == dfl_pkg::OFS_CTRL && serial_access_i &&
               hwdata_i[dfl_pkg::CTRL_ESEL];
  assign irq_evt = {rej, next_state == dfl_pkg::DFL_FROZEN && state == dfl_pkg::DFL_RUN,
                    snap, tlog.push};
  assign irq_clr = (wr_ok && a_ofs == dfl_pkg::OFS_IRQ_CLR) ? hwdata_i[IRQ_W-1:0] : '0;

  // A new event in the clearing cycle wins so it is never lost.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      irq_stat <= '0;
      irq_o    <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_evt;
      irq_o    <= |(((irq_stat & ~irq_clr) | irq_evt) & irq_en);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_SNAP_PERIOD: assert property (@(posedge clock_i) disable iff (rst_i)
    snap |-> $past(state) == dfl_pkg::DFL_RUN && samp_cnt == SAMPLE_CYCLES - 1)
    else $error("snapshot outside the sampling period");
  AST_FREEZE: assert property (@(posedge clock_i) disable iff (rst_i)
    state == dfl_pkg::DFL_RUN && (trip_i || stop_i) |-> !snap ##1
    (state == dfl_pkg::DFL_FROZEN && !snap))
    else $error("sampling went on after trip or stop");
  AST_CWORD_SERIAL: assert property (@(posedge clock_i) disable iff (rst_i)
    !$past(rst_i) && $changed(cword) |-> $past(wr_ok) && $past(serial_access_i))
    else $error("control word changed without a serial write");
  AST_TRIP_CODE: assert property (@(posedge clock_i) disable iff (rst_i)
    tlog.push |-> tlog.wdata[6:0] <= dfl_pkg::CODE_MAX)
    else $error("logged error code above 99");
  AST_TRIP_VALUE: assert property (@(posedge clock_i) disable iff (rst_i)
    tlog.push |-> tlog.wdata[20:7] <= dfl_pkg::VALUE_MAX)
    else $error("logged trip value above 9999");
  AST_OV_GATE: assert property (@(posedge clock_i) disable iff (rst_i)
    !$past(rst_i) && ovolt_cnt != $past(ovolt_cnt) |->
    $past(active_alarm_i) == dfl_pkg::OV_ALARM)
    else $error("overvoltage counted without alarm 7");
  AST_ECLEAR: assert property (@(posedge clock_i) disable iff (rst_i)
    e_clear |=> kwh == '0 && !esel)
    else $error("energy counter not cleared on confirmation");
  AST_SERIAL_REJ: assert property (@(posedge clock_i) disable iff (rst_i)
    !esel && wr_ok && serial_access_i |=> !esel)
    else $error("energy reset selected over the serial port");
  AST_CONN: assert property (@(posedge clock_i) disable iff (rst_i)
    pin_q[8] && !supply_q_d && conn_cnt < dfl_pkg::CNT_MAX |=> conn_cnt == $past(conn_cnt) + 16'h1)
    else $error("supply application not counted");
  COV_SNAP: cover property (@(posedge clock_i) disable iff (rst_i) snap);
  COV_FROZEN: cover property (@(posedge clock_i) disable iff (rst_i)
    state == dfl_pkg::DFL_RUN ##1 state == dfl_pkg::DFL_FROZEN);
  COV_TRIP: cover property (@(posedge clock_i) disable iff (rst_i) tlog.push);
  COV_ECLR: cover property (@(posedge clock_i) disable iff (rst_i) e_clear);
endmodule

// ==== tb/dfl_host.sv ====
// Purpose: AHB-Lite master model standing in for host software.
// Assumes: One slave whose hreadyout is fed back as hready.
// Notes:   Both waits of a transfer share one limit of 50 stalled edges; reaching it raises hung_o.
`timescale 1ns/100ps
module dfl_host (
  input  wire logic        clock_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  output logic      [31:0] haddr_o = 32'h0,
  output logic      [1:0]  htrans_o = 2'h0,
  output logic             hwrite_o = 1'b0,
  output logic      [31:0] hwdata_o = 32'h0,
  output logic             hung_o = 1'b0
);
  // One single word transfer; the request holds until hready is sampled high.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    haddr_o  <= {24'h0, a};
    htrans_o <= dfl_pkg::HTRANS_NONSEQ;
    hwrite_o <= w;
    do @(posedge clock_i); while (!hready_i && ++n < 50);
    htrans_o <= 2'h0;
    hwdata_o <= d;
    do @(posedge clock_i); while (!hready_i && ++n < 50);
    q = hrdata_i;
    hung_o <= hung_o | (n >= 50);
  endtask
endmodule

// ==== tb/dfl_logger_tb_top.sv ====
// Purpose: Self-checking bench for the drive data and fault logger.
// Assumes: Short sample and second periods so the run stays brief.
// Notes:   The trip log is read again after a reset, as it must survive one.
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; \
  $display("unexpected %0t: %h not %h", $time, (a), (e)); end end
module dfl_logger_tb_top;
  logic        clk = 0, rst = 1, ser = 0, ok = 0, st = 0, sp = 0, tr = 0;
  logic        sup = 0, ot = 0, ov = 0, rdy, irq, hw, hung, hresp;
  logic [4:0]  pidx = 5'h01;
  logic [3:0]  pfld = 4'h8;
  logic [15:0] pdat;
  logic [6:0]  code = 0, alarm = 0;
  logic [13:0] val = 0;
  logic [20:0] hrs = 0;
  logic [7:0]  din = 8'h28;
  logic [15:0] qty = 16'h1357;
  logic [31:0] ha, hd, q, hr;
  logic [1:0]  ht;
  int          fails = 0, cmp_count = 0;
  // Free-running 20 MHz clock.
  always #25 clk = ~clk;
  dfl_logger #(.SAMPLE_CYCLES(20), .SEC_CYCLES(4)) dfl_logger_inst (
    .clock_i(clk), .rst_i(rst), .hsel_i(1'b1), .haddr_i(ha), .htrans_i(ht),
    .hwrite_i(hw), .hsize_i(3'h2), .hwdata_i(hd), .hready_i(rdy), .hrdata_o(hr),
    .hreadyout_o(rdy), .hresp_o(hresp), .serial_access_i(ser), .ok_key_i(ok),
    .start_i(st), .stop_i(sp), .trip_i(tr), .trip_code_i(code), .trip_value_i(val),
    .run_hours_i(hrs), .din_pin_i(din), .supply_pin_i(sup), .status_word_i(qty),
    .ref_i(qty), .fb_i(qty), .freq_i(qty), .volt_i(qty), .curr_i(qty), .dc_i(~qty),
    .power_w_i(qty), .heat_ot_i(ot), .ov_event_i(ov), .active_alarm_i(alarm),
    .panel_idx_i(pidx), .panel_field_i(pfld), .panel_data_o(pdat), .irq_o(irq));
  dfl_host dfl_host_inst (.clock_i(clk), .hready_i(rdy), .hrdata_i(hr), .haddr_o(ha),
    .htrans_o(ht), .hwrite_o(hw), .hwdata_o(hd), .hung_o(hung));
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    dfl_host_inst.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a);
    dfl_host_inst.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Serial energy-reset refusal raises the interrupt; the local path works.
  task automatic t_irq;
    wr(dfl_pkg::OFS_IRQ_EN, 32'h8);
    ser <= 1'b1;
    wr(dfl_pkg::OFS_CTRL, 32'h2);
    ser <= 1'b0;
    rd(dfl_pkg::OFS_CTRL);
    `CHK({q[1], irq}, 2'b01)
    wr(dfl_pkg::OFS_IRQ_CLR, 32'h8);
    wr(dfl_pkg::OFS_CTRL, 32'h2);
    rd(dfl_pkg::OFS_STATUS);
    `CHK({q[2], irq}, 2'b10)
    ok <= 1'b1;
    tick(1);
    ok <= 1'b0;
    rd(dfl_pkg::OFS_STATUS);
    `CHK(q[2], 1'b0)
    rd(8'h0C);
    `CHK({hresp, q}, 33'h0)
    $display("irq test done");
  endtask
  // Event counters; an overvoltage outside alarm 7 is not counted.
  task automatic t_cnt;
    sup <= 1'b1;
    ot <= 1'b1;
    ov <= 1'b1;
    tick(1);
    ot <= 1'b0;
    ov <= 1'b0;
    alarm <= dfl_pkg::OV_ALARM;
    tick(1);
    ov <= 1'b1;
    tick(1);
    ov <= 1'b0;
    // The supply pin needs its three synchroniser stages before it is counted.
    tick(3);
    rd(dfl_pkg::OFS_CONN);
    `CHK(q, 32'h1)
    rd(dfl_pkg::OFS_OTEMP);
    `CHK(q, 32'h1)
    rd(dfl_pkg::OFS_OVOLT);
    `CHK(q, 32'h1)
    $display("counter test done");
  endtask
  // Two snapshots with different inputs, then a stop freezes them.
  task automatic t_dlog;
    ser <= 1'b1;
    wr(dfl_pkg::OFS_CWORD, 32'hBEEF);
    ser <= 1'b0;
    wr(dfl_pkg::OFS_CWORD, 32'h1234);
    st <= 1'b1;
    tick(1);
    st <= 1'b0;
    tick(30);
    din <= 8'h81;
    tick(20);
    sp <= 1'b1;
    tick(1);
    sp <= 1'b0;
    din <= 8'h00;
    pidx <= 5'h02;
    pfld <= 4'h0;
    tick(40);
    rd(dfl_pkg::OFS_STATUS);
    `CHK(q[1:0], 2'h3)
    `CHK(pdat, 16'h0028)
    wr(dfl_pkg::OFS_DSEL, 32'h001);
    rd(dfl_pkg::OFS_DDATA);
    `CHK(q, 32'h81)
    wr(dfl_pkg::OFS_DSEL, 32'h002);
    rd(dfl_pkg::OFS_DDATA);
    `CHK(q, 32'h28)
    wr(dfl_pkg::OFS_DSEL, 32'h101);
    rd(dfl_pkg::OFS_DDATA);
    `CHK(q, 32'hBEEF)
    wr(dfl_pkg::OFS_DSEL, 32'h801);
    rd(dfl_pkg::OFS_DDATA);
    `CHK(q, 32'hECA8)
    $display("data log test done");
  endtask
  // Back-to-back trips, the second clamped, then a reset mid-run.
  task automatic t_trip;
    code <= 7'h05;
    val <= 14'h0064;
    hrs <= 21'h32;
    tr <= 1'b1;
    tick(1);
    code <= 7'h7F;
    val <= 14'h3FFF;
    hrs <= 21'h1FFFFF;
    tick(1);
    tr <= 1'b0;
    wr(dfl_pkg::OFS_TSEL, 32'h1);
    rd(dfl_pkg::OFS_TCODE);
    `CHK(q, 32'h270F0063)
    rd(dfl_pkg::OFS_THOURS);
    `CHK(q, {11'h0, dfl_pkg::HOURS_MAX})
    `CHK(irq, 1'b0)
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    wr(dfl_pkg::OFS_TSEL, 32'h2);
    rd(dfl_pkg::OFS_TCODE);
    `CHK(q, 32'h00640005)
    // An hour is 3600 seconds of four cycles from the reset; 0x1357 W gives 4 kWh.
    tick(14500);
    rd(dfl_pkg::OFS_ENERGY);
    `CHK(q, 32'h4)
    $display("trip log test done");
  endtask
  task automatic end_of_test;
    if (hung) fails++;
    $display("comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Reset for 20 cycles, then the scenarios in turn.
  initial begin
    tick(20);
    rst <= 1'b0;
    t_irq();
    t_cnt();
    t_dlog();
    t_trip();
    end_of_test();
  end
endmodule
